// File: logic/reset_source_sequencer.sv
// What this block does
// R1: power, clock/lock loss, undervolt, stop-mode pin are async; pin and software sync.
// R2: sync source waits for bus cycle end, then reset on next edge.
// R3: during that wait the bus monitor is forced on and times out the cycle.
// R4: a cycle in flight ends before reset, or is cut short by the bus monitor time-out.
// R5: async source asserts reset at once without waiting for the bus.
// R6: power-up holds reset until supply good and lock, then 512 more cycles.
// R7: pin must be low four edges before the request is taken.
// R8: pin assertion in stop mode is still taken as an external reset.
// R9: clock loss reset when enabled in pll mode and reference or pll fails.
// R10: lock loss reset when enabled in pll mode and the pll unlocks.
// R11: software request bit starts a reset released after pin, lock, 512 cycles.
// R12: sync request is latched, monitor enabled, reset asserted at cycle end.
// R13: after pin and lock count 512 cycles, capture boot config, then release.
// R14: qualified pin during count or lock wait returns to pin wait.
// R15: internal async source asserts reset, waits lock, counts, captures, releases.
// R16: lock lost during the count returns to lock wait.
// R17: power-on or undervolt restarts the sequence from its first state.
// R18: clock or lock loss during bus wait ends cycle, latches cause, waits pin.
// R19: power-on sets powerup and undervolt flags, clears the other four.
// R20: loss during bus wait sets pin/program flag together with loss flag.
// R21: plain pin/software or plain internal sequence sets only its own flags.
// R22: undervolt reset sets undervolt flag, clears program, pin, loss flags.
// R23: cause flags readable anytime, writes ignored, each reset overwrites them.
// R24: undervolt reset takes priority over the undervolt interrupt.
// R25: pin passes a two-flop synchroniser before its edges are counted.
// R26: release count is exact 512, reloaded on each return to lock or pin wait.
`timescale 1ns/1ps
module reset_source_sequencer
   import rst_seq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // supply and pll status
   input wire logic power_ok,
   input wire logic undervolt_det,
   input wire logic pll_mode,
   input wire logic pll_locked,
   input wire logic pll_ref_fail,
   input wire logic pll_fail,
   input wire logic stop_mode,
   // reset and configuration pins
   input wire logic pin_reset_in_n,
   input wire logic boot_cfg_sel_n,
   output logic reset_out_n,
   output logic boot_cfg_level,
   // bus monitor
   input wire logic bus_cycle_active,
   input wire logic bus_cycle_done,
   output logic busmon_force,
   output logic busmon_term,
   // undervolt interrupt request
   output logic undervolt_irq_req
);
   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and qualifier
   logic pin_meta_reg;
   logic pin_s2_reg;
   logic [2:0] pin_cnt_reg;
   logic [2:0] pin_cnt_next;
   logic pin_qual;
   always_comb begin
      pin_cnt_next = pin_cnt_reg;
      if (pin_s2_reg) begin
         pin_cnt_next = 3'h0;
      end else if (pin_cnt_reg != PIN_QUAL_EDGES) begin
         pin_cnt_next = pin_cnt_reg + 3'h1; // R7
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
         pin_cnt_reg <= 3'h0;
      end else begin
         pin_meta_reg <= pin_reset_in_n; // R25
         pin_s2_reg <= pin_meta_reg; // R25
         pin_cnt_reg <= pin_cnt_next;
      end
   end
   assign pin_qual = (pin_cnt_reg == PIN_QUAL_EDGES); // R7

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic busmon_en_reg;
   logic busmon_en_next;
   logic [7:0] busmon_limit_reg;
   logic [7:0] busmon_limit_next;
   logic clk_fail_reset_en_reg;
   logic clk_fail_reset_en_next;
   logic unlock_reset_en_reg;
   logic unlock_reset_en_next;
   logic [2:0] uv_ctl_reg;
   logic [2:0] uv_ctl_next;
   logic prog_pend_reg;
   logic prog_pend_next;
   logic [31:0] rdata_next;
   logic [7:0] cause_reg;
   logic prog_take;
   logic cfg_level_reg;
   seq_state_t st_reg;

   always_comb begin
      busmon_en_next = busmon_en_reg;
      busmon_limit_next = busmon_limit_reg;
      clk_fail_reset_en_next = clk_fail_reset_en_reg;
      unlock_reset_en_next = unlock_reset_en_reg;
      uv_ctl_next = uv_ctl_reg;
      // set wins over the clear by the sequencer
      prog_pend_next = prog_pend_reg & ~prog_take;
      rdata_next = 32'h0;
      if (reg_wr) begin
         unique case (reg_addr)
            CHIP_CFG_OFS: begin
               busmon_en_next = reg_wdata[BUSMON_EN_BIT];
               busmon_limit_next = reg_wdata[BUSMON_LIMIT_LSB +: 8];
            end
            PLL_CTL_OFS: begin
               clk_fail_reset_en_next = reg_wdata[CLK_FAIL_EN_BIT];
               unlock_reset_en_next = reg_wdata[UNLOCK_EN_BIT];
            end
            RESET_CTL_OFS: begin
               uv_ctl_next = reg_wdata[UV_IRQ_EN_BIT:UV_EN_BIT];
               if (reg_wdata[PROG_REQ_BIT]) begin
                  prog_pend_next = 1'b1; // R11
               end
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            CHIP_CFG_OFS: begin
               rdata_next[BUSMON_EN_BIT] = busmon_en_reg;
               rdata_next[BUSMON_LIMIT_LSB +: 8] = busmon_limit_reg;
            end
            PLL_CTL_OFS: begin
               rdata_next[CLK_FAIL_EN_BIT] = clk_fail_reset_en_reg;
               rdata_next[UNLOCK_EN_BIT] = unlock_reset_en_reg;
            end
            RESET_CTL_OFS: begin
               rdata_next[PROG_REQ_BIT] = prog_pend_reg;
               rdata_next[UV_IRQ_EN_BIT:UV_EN_BIT] = uv_ctl_reg;
            end
            CAUSE_OFS: rdata_next[7:0] = cause_reg; // R23
            BOOT_CFG_OFS: begin
               rdata_next[0] = cfg_level_reg;
               rdata_next[14:8] = st_reg;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busmon_en_reg <= BUSMON_EN_RST;
         busmon_limit_reg <= BUSMON_LIMIT_RST;
         clk_fail_reset_en_reg <= PLL_CTL_RST[CLK_FAIL_EN_BIT];
         unlock_reset_en_reg <= PLL_CTL_RST[UNLOCK_EN_BIT];
         uv_ctl_reg <= UV_CTL_RST;
         prog_pend_reg <= 1'b0;
         reg_rdata <= 32'h0;
      end else begin
         busmon_en_reg <= busmon_en_next;
         busmon_limit_reg <= busmon_limit_next;
         clk_fail_reset_en_reg <= clk_fail_reset_en_next;
         unlock_reset_en_reg <= unlock_reset_en_next;
         uv_ctl_reg <= uv_ctl_next;
         prog_pend_reg <= prog_pend_next;
         reg_rdata <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source classification
   logic uv_rst;
   logic por_evt;
   logic clk_loss;
   logic lock_loss;
   logic any_loss;
   logic locked_ok;
   assign uv_rst = undervolt_det & uv_ctl_reg[0] & uv_ctl_reg[1];
   assign por_evt = ~power_ok | uv_rst; // R1
   assign clk_loss = pll_mode & clk_fail_reset_en_reg & (pll_ref_fail | pll_fail); // R9
   assign lock_loss = pll_mode & unlock_reset_en_reg & ~pll_locked; // R10
   assign any_loss = clk_loss | lock_loss;
   assign locked_ok = ~pll_mode | pll_locked;
   assign undervolt_irq_req = undervolt_det & uv_ctl_reg[0] & uv_ctl_reg[2] & ~uv_rst; // R24

   ////////////////////////////////////////////////////////////////////////////
   // bus monitor
   logic [7:0] bm_cnt_reg;
   logic [7:0] bm_cnt_next;
   logic bm_run;
   logic bm_to;
   logic term_reg;
   logic term_next;
   assign bm_run = (busmon_en_reg | (st_reg == S_SYNC)) & bus_cycle_active & ~bus_cycle_done; // R3
   assign bm_to = bm_run & (bm_cnt_reg == busmon_limit_reg); // R3
   assign bm_cnt_next = (bm_run & ~bm_to) ? bm_cnt_reg + 8'h1 : 8'h0;
   assign term_next = bm_to | ((st_reg == S_SYNC) & any_loss & ~por_evt); // R18
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bm_cnt_reg <= 8'h0;
         term_reg <= 1'b0;
      end else begin
         bm_cnt_reg <= bm_cnt_next;
         term_reg <= term_next;
      end
   end
   assign busmon_term = term_reg;
   assign busmon_force = (st_reg == S_SYNC); // R3 R12

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   seq_state_t st_next;
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic [7:0] cause_next;
   logic [1:0] pend_reg;
   logic [1:0] pend_next;
   logic cfg_level_next;
   logic rout_reg;
   logic rout_next;
   logic bus_end;
   assign bus_end = ~bus_cycle_active | bus_cycle_done | bm_to; // R2 R4

   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      cause_next = cause_reg;
      pend_next = pend_reg;
      cfg_level_next = cfg_level_reg;
      prog_take = 1'b0;
      if (por_evt) begin
         st_next = S_INIT; // R17
         cause_next = power_ok ? UV_CAUSE : POR_CAUSE; // R19 R22
      end else begin
         unique case (st_reg)
            S_INIT: st_next = S_LOCK; // R6
            S_RUN: begin
               if (any_loss | (pin_qual & stop_mode)) begin
                  st_next = (pin_qual & stop_mode) ? S_PIN : S_LOCK; // R5 R8 R15
                  cause_next = 8'h0; // R21 R23
                  cause_next[PIN_FLAG_BIT] = pin_qual;
                  cause_next[PROG_FLAG_BIT] = prog_pend_reg;
                  cause_next[CLK_FAIL_FLAG_BIT] = clk_loss;
                  cause_next[UNLOCK_FLAG_BIT] = lock_loss;
                  prog_take = 1'b1;
               end else if (pin_qual | prog_pend_reg) begin
                  st_next = S_SYNC; // R2 R12
                  pend_next = {pin_qual, prog_pend_reg};
                  prog_take = 1'b1;
               end
            end
            S_SYNC: begin
               pend_next = pend_reg | {pin_qual, prog_pend_reg};
               prog_take = 1'b1;
               if (any_loss | bus_end) begin
                  st_next = S_PIN; // R2 R18
                  cause_next = 8'h0; // R21
                  cause_next[PIN_FLAG_BIT] = pend_next[1];
                  cause_next[PROG_FLAG_BIT] = pend_next[0];
                  cause_next[CLK_FAIL_FLAG_BIT] = clk_loss; // R20
                  cause_next[UNLOCK_FLAG_BIT] = lock_loss; // R20
               end
            end
            S_PIN: begin
               if (pin_s2_reg) begin
                  st_next = S_LOCK; // R11 R12
               end
            end
            S_LOCK: begin
               if (pin_qual) begin
                  st_next = S_PIN; // R14
               end else if (locked_ok) begin
                  st_next = S_COUNT; // R6 R15
               end
            end
            S_COUNT: begin
               if (pin_qual) begin
                  st_next = S_PIN; // R14
               end else if (~locked_ok) begin
                  st_next = S_LOCK; // R16
               end else if (cnt_reg == 9'h0) begin
                  st_next = S_CFG; // R13
               end else begin
                  cnt_next = cnt_reg - 9'h1;
               end
            end
            S_CFG: begin
               cfg_level_next = boot_cfg_sel_n; // R13
               st_next = S_RUN;
            end
         endcase
      end
      if (st_next == S_LOCK || st_next == S_PIN || st_next == S_INIT) begin
         cnt_next = RELEASE_LOAD; // R26
      end
      rout_next = (st_next == S_RUN) || (st_next == S_SYNC); // R2 R5
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= S_INIT;
         cnt_reg <= RELEASE_LOAD;
         cause_reg <= CAUSE_RST;
         pend_reg <= 2'h0;
         cfg_level_reg <= 1'b1;
         rout_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         cause_reg <= cause_next;
         pend_reg <= pend_next;
         cfg_level_reg <= cfg_level_next;
         rout_reg <= rout_next;
      end
   end
   assign reset_out_n = rout_reg;
   assign boot_cfg_level = cfg_level_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_async_immediate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
      (st_reg == S_RUN && any_loss && !por_evt) |=> !reset_out_n && st_reg == S_LOCK)
      else $error("async source did not assert reset at once");
   a_sync_waits_bus: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
      (st_reg == S_SYNC && !bus_end && !any_loss && !por_evt) |=> reset_out_n)
      else $error("sync reset asserted before bus cycle ended");
   a_monitor_forced: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      (st_reg == S_SYNC && bus_cycle_active && !bus_cycle_done
       && bm_cnt_reg == busmon_limit_reg) |=> busmon_term)
      else $error("bus monitor did not end the cycle in sync wait");
   a_pin_qualify: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      pin_qual |-> !$past(pin_s2_reg, 1) && !$past(pin_s2_reg, 2)
                   && !$past(pin_s2_reg, 3) && !$past(pin_s2_reg, 4))
      else $error("pin taken before four low edges");
   a_count_end: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
      $rose(st_reg == S_CFG) |-> $past(cnt_reg) == 9'h0 && $past(st_reg) == S_COUNT
      ##1 reset_out_n && boot_cfg_level == $past(boot_cfg_sel_n))
      else $error("release without full count or config capture");
   a_count_reload: assert property (@(posedge ref_clk) disable iff (!rst_n) // R26
      (st_reg == S_LOCK) ##1 (st_reg == S_COUNT) |-> cnt_reg == RELEASE_LOAD)
      else $error("release counter not reloaded");
   a_pin_restart: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
      ((st_reg == S_COUNT || st_reg == S_LOCK) && pin_qual && !por_evt) |=> st_reg == S_PIN)
      else $error("qualified pin did not return to pin wait");
   a_lock_lost: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
      (st_reg == S_COUNT && !locked_ok && !pin_qual && !por_evt) |=> st_reg == S_LOCK)
      else $error("lock loss during count not handled");
   a_power_restart: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
      por_evt |=> st_reg == S_INIT && !reset_out_n)
      else $error("power event did not restart sequence");
   a_por_flags: assert property (@(posedge ref_clk) disable iff (!rst_n) // R19
      !power_ok |=> cause_reg == POR_CAUSE)
      else $error("power-on cause flags wrong");
   a_uv_flags: assert property (@(posedge ref_clk) disable iff (!rst_n) // R22
      (power_ok && uv_rst) |=> cause_reg == UV_CAUSE)
      else $error("undervolt cause flags wrong");
   a_loss_in_wait: assert property (@(posedge ref_clk) disable iff (!rst_n) // R20
      (st_reg == S_SYNC && clk_loss && pend_reg != 2'h0 && !por_evt)
      |=> (!$past(pend_reg[1]) || cause_reg[PIN_FLAG_BIT])
          && (!$past(pend_reg[0]) || cause_reg[PROG_FLAG_BIT])
          && cause_reg[CLK_FAIL_FLAG_BIT] && st_reg == S_PIN)
      else $error("loss during bus wait flags wrong");
   a_uv_priority: assert property (@(posedge ref_clk) disable iff (!rst_n) // R24
      uv_rst |-> !undervolt_irq_req)
      else $error("undervolt interrupt raised while reset enabled");
endmodule : reset_source_sequencer

// File: common/rst_seq_pkg.sv
package rst_seq_pkg;
   // register map, byte addresses on the register port
   localparam logic [7:0] CHIP_CFG_OFS = 8'h00;
   localparam logic [7:0] PLL_CTL_OFS = 8'h04;
   localparam logic [7:0] RESET_CTL_OFS = 8'h08;
   localparam logic [7:0] CAUSE_OFS = 8'h0c;
   localparam logic [7:0] BOOT_CFG_OFS = 8'h10;
   // chip_cfg_reg fields
   localparam int BUSMON_EN_BIT = 0;
   localparam int BUSMON_LIMIT_LSB = 8;
   // pll_ctl_reg fields
   localparam int CLK_FAIL_EN_BIT = 0;
   localparam int UNLOCK_EN_BIT = 1;
   // reset_ctl_reg fields
   localparam int PROG_REQ_BIT = 0;
   localparam int UV_EN_BIT = 1;
   localparam int UV_RST_EN_BIT = 2;
   localparam int UV_IRQ_EN_BIT = 3;
   // reset_cause_reg fields
   localparam int UNLOCK_FLAG_BIT = 0;
   localparam int CLK_FAIL_FLAG_BIT = 1;
   localparam int PIN_FLAG_BIT = 2;
   localparam int POWERUP_FLAG_BIT = 3;
   localparam int PROG_FLAG_BIT = 5;
   localparam int UV_FLAG_BIT = 6;
   // values after reset
   localparam logic [7:0] CAUSE_RST = 8'h48;
   localparam logic [7:0] POR_CAUSE = 8'h48;
   localparam logic [7:0] UV_CAUSE = 8'h40;
   localparam logic [7:0] BUSMON_LIMIT_RST = 8'hff;
   localparam logic BUSMON_EN_RST = 1'b0;
   localparam logic [1:0] PLL_CTL_RST = 2'h0;
   localparam logic [2:0] UV_CTL_RST = 3'h3;
   // cycle counts
   localparam int RELEASE_CYCLES = 512;
   localparam logic [8:0] RELEASE_LOAD = 9'(RELEASE_CYCLES - 1);
   localparam logic [2:0] PIN_QUAL_EDGES = 3'h4;
   typedef enum logic [6:0] {
      S_INIT = 7'h01,
      S_RUN = 7'h02,
      S_SYNC = 7'h04,
      S_PIN = 7'h08,
      S_LOCK = 7'h10,
      S_COUNT = 7'h20,
      S_CFG = 7'h40
   } seq_state_t;
endpackage : rst_seq_pkg

// File: bench/board_reset_model.sv
`timescale 1ns/1ps
module board_reset_model (
   // clock
   input wire logic ref_clk,
   // request from the bench
   input wire logic start,
   input wire logic [7:0] hold_cycles,
   // reset pin, pulled up while released
   output logic pin_reset_in_n
);
   logic [7:0] left_reg;
   initial begin
      left_reg = 8'h00;
      pin_reset_in_n = 1'b1;
   end
   // pin stays low for exactly the requested count of rising edges
   always @(posedge ref_clk) begin
      if (start) begin
         left_reg <= hold_cycles;
         pin_reset_in_n <= 1'b0;
      end else if (left_reg > 8'h01) begin
         left_reg <= left_reg - 8'h01;
      end else begin
         left_reg <= 8'h00;
         pin_reset_in_n <= 1'b1;
      end
   end
endmodule : board_reset_model

// File: bench/reset_source_sequencer_bench.sv
`timescale 1ns/1ps
module reset_source_sequencer_bench
   import rst_seq_pkg::*;
;
   logic ref_clk, arst_n, reg_wr, reg_rd, power_ok, undervolt_det, pll_mode;
   logic pll_locked, pll_ref_fail, pll_fail, stop_mode, boot_cfg_sel_n;
   logic bus_cycle_active, bus_cycle_done, start, pin_reset_in_n;
   logic reset_out_n, boot_cfg_level, busmon_force, busmon_term, undervolt_irq_req;
   logic [7:0] reg_addr, hold_cycles;
   logic [31:0] reg_wdata, reg_rdata, rd;
   int num_errors, check_count, term_cnt, n;

   reset_source_sequencer dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .power_ok(power_ok), .undervolt_det(undervolt_det), .pll_mode(pll_mode),
      .pll_locked(pll_locked), .pll_ref_fail(pll_ref_fail), .pll_fail(pll_fail),
      .stop_mode(stop_mode), .pin_reset_in_n(pin_reset_in_n),
      .boot_cfg_sel_n(boot_cfg_sel_n), .reset_out_n(reset_out_n),
      .boot_cfg_level(boot_cfg_level), .bus_cycle_active(bus_cycle_active),
      .bus_cycle_done(bus_cycle_done), .busmon_force(busmon_force),
      .busmon_term(busmon_term), .undervolt_irq_req(undervolt_irq_req));
   board_reset_model board (.ref_clk(ref_clk), .start(start), .hold_cycles(hold_cycles),
      .pin_reset_in_n(pin_reset_in_n));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (busmon_term === 1'b1) term_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (num_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : tick
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask : reg_read
   // bounded wait for reset_out_n to reach v; k counts the cycles spent
   task automatic wait_out(input logic v, input int lim, output int k);
      k = 0;
      while (reset_out_n !== v) begin
         @(negedge ref_clk);
         k++;
         if (k > lim) begin
            chk("reset_out_n wait", 32'(v), 32'(reset_out_n));
            close_out();
         end
      end
   endtask : wait_out
   task automatic release_and_cause(input logic [31:0] exp);
      wait_out(1'b1, 600, n);
      chk("release cycles", 32'h1, 32'(n >= 512 && n <= 524));
      reg_read(CAUSE_OFS, rd);
      chk("cause flags", exp, rd);
   endtask : release_and_cause
   task automatic pin_pulse(input logic [7:0] h);
      @(posedge ref_clk);
      start <= 1'b1;
      hold_cycles <= h;
      @(posedge ref_clk);
      start <= 1'b0;
      tick(int'(h) + 1);
   endtask : pin_pulse

   ////////////////////////////////////////////////////////////////////////////
   task automatic s_power_on();
      tick(20);
      @(negedge ref_clk);
      chk("reset held without supply", 32'h0, 32'(reset_out_n));
      reg_write(CAUSE_OFS, 32'h0);
      reg_read(CAUSE_OFS, rd);
      chk("cause after write", 32'(CAUSE_RST), rd);
      @(posedge ref_clk);
      power_ok <= 1'b1;
      release_and_cause(32'(POR_CAUSE));
      reg_read(CHIP_CFG_OFS, rd);
      chk("chip_cfg_reg", {16'h0, BUSMON_LIMIT_RST, 7'h0, BUSMON_EN_RST}, rd);
      reg_read(PLL_CTL_OFS, rd);
      chk("pll_ctl_reg", {30'h0, PLL_CTL_RST}, rd);
      reg_read(RESET_CTL_OFS, rd);
      chk("reset_ctl_reg", {28'h0, UV_CTL_RST, 1'b0}, rd);
      reg_read(8'h20, rd);
      chk("unmapped read", 32'h0, rd);
   endtask : s_power_on
   task automatic s_soft_bus_done();
      @(posedge ref_clk);
      bus_cycle_active <= 1'b1;
      reg_write(RESET_CTL_OFS, 32'h7);
      tick(10);
      @(negedge ref_clk);
      chk("monitor forced", 32'h1, 32'(busmon_force));
      chk("reset waits for bus", 32'h1, 32'(reset_out_n));
      @(posedge ref_clk);
      bus_cycle_done <= 1'b1;
      @(posedge ref_clk);
      bus_cycle_done <= 1'b0;
      bus_cycle_active <= 1'b0;
      wait_out(1'b0, 2, n);
      release_and_cause(32'h1 << PROG_FLAG_BIT);
   endtask : s_soft_bus_done
   task automatic s_bus_timeout();
      reg_write(CHIP_CFG_OFS, 32'h0000_1000);
      @(posedge ref_clk);
      bus_cycle_active <= 1'b1;
      term_cnt = 0;
      reg_write(RESET_CTL_OFS, 32'h7);
      wait_out(1'b0, 40, n);
      chk("timeout window", 32'h1, 32'(n >= 14 && n <= 24));
      @(posedge ref_clk);
      bus_cycle_active <= 1'b0;
      release_and_cause(32'h1 << PROG_FLAG_BIT);
      // the termination pulse is counted one edge after reset_out_n falls
      chk("monitor terminated", 32'h1, 32'(term_cnt));
   endtask : s_bus_timeout
   task automatic s_pin(input logic stop);
      @(posedge ref_clk);
      stop_mode <= stop;
      bus_cycle_active <= stop;
      pin_pulse(8'h03);
      tick(8);
      @(negedge ref_clk);
      chk("short pin ignored", 32'h1, 32'(reset_out_n));
      @(posedge ref_clk);
      boot_cfg_sel_n <= 1'b0;
      pin_pulse(8'h08);
      wait_out(1'b0, 4, n);
      @(posedge ref_clk);
      stop_mode <= 1'b0;
      bus_cycle_active <= 1'b0;
      release_and_cause(32'h1 << PIN_FLAG_BIT);
      chk("boot config captured", 32'h0, 32'(boot_cfg_level));
      @(posedge ref_clk);
      boot_cfg_sel_n <= 1'b1;
   endtask : s_pin
   task automatic s_pin_in_count();
      pin_pulse(8'h08);
      tick(300);
      @(negedge ref_clk);
      chk("still counting", 32'h0, 32'(reset_out_n));
      pin_pulse(8'h08);
      release_and_cause(32'h1 << PIN_FLAG_BIT);
   endtask : s_pin_in_count
   task automatic s_loss(input int k);
      reg_write(PLL_CTL_OFS, 32'h3);
      @(posedge ref_clk);
      pll_mode <= 1'b1;
      if (k == 0) pll_locked <= 1'b0;
      else pll_ref_fail <= 1'b1;
      wait_out(1'b0, 2, n);
      tick(20);
      @(negedge ref_clk);
      chk("waits for lock", 32'h0, 32'(reset_out_n));
      @(posedge ref_clk);
      pll_locked <= 1'b1;
      pll_ref_fail <= 1'b0;
      tick(100);
      pll_locked <= 1'b0;
      tick(10);
      pll_locked <= 1'b1;
      release_and_cause(k == 0 ? 32'h1 << UNLOCK_FLAG_BIT : 32'h1 << CLK_FAIL_FLAG_BIT);
   endtask : s_loss
   task automatic s_loss_in_sync();
      reg_write(PLL_CTL_OFS, 32'h1);
      @(posedge ref_clk);
      bus_cycle_active <= 1'b1;
      reg_write(RESET_CTL_OFS, 32'h7);
      tick(5);
      pll_fail <= 1'b1;
      wait_out(1'b0, 3, n);
      @(posedge ref_clk);
      pll_fail <= 1'b0;
      bus_cycle_active <= 1'b0;
      release_and_cause((32'h1 << PROG_FLAG_BIT) | (32'h1 << CLK_FAIL_FLAG_BIT));
   endtask : s_loss_in_sync
   task automatic s_undervolt();
      reg_write(RESET_CTL_OFS, 32'ha);
      @(posedge ref_clk);
      undervolt_det <= 1'b1;
      @(negedge ref_clk);
      chk("irq without reset", 32'h1, 32'(undervolt_irq_req));
      @(posedge ref_clk);
      undervolt_det <= 1'b0;
      reg_write(RESET_CTL_OFS, 32'he);
      @(posedge ref_clk);
      undervolt_det <= 1'b1;
      @(negedge ref_clk);
      chk("reset beats irq", 32'h0, 32'(undervolt_irq_req));
      wait_out(1'b0, 3, n);
      pin_pulse(8'h08);
      @(posedge ref_clk);
      undervolt_det <= 1'b0;
      release_and_cause(32'(UV_CAUSE));
   endtask : s_undervolt

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {arst_n, reg_wr, reg_rd, power_ok, undervolt_det, pll_mode, pll_ref_fail} = '0;
      {pll_fail, stop_mode, bus_cycle_active, bus_cycle_done, start} = '0;
      {pll_locked, boot_cfg_sel_n} = 2'b11;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      hold_cycles = 8'h00;
      num_errors = 0;
      check_count = 0;
      term_cnt = 0;
      tick(12);
      arst_n <= 1'b1;
      tick(3);
      s_power_on();
      s_soft_bus_done();
      s_bus_timeout();
      s_pin(1'b0);
      s_pin(1'b1);
      s_pin_in_count();
      s_loss(0);
      s_loss(1);
      s_loss_in_sync();
      s_undervolt();
      close_out();
   end
endmodule : reset_source_sequencer_bench
